// [rtl/ssp_pkg.sv]
// Purpose: shared constants of the serial port block (codes, framing, timing)
// Assumes: core_clk runs at 20 MHz
// Notes: every configuration code of value zero selects the power-up default

package ssp_pkg;

  // ------------
  // clock and bit timing
  // ------------
  localparam int unsigned CLK_HZ = 20_000_000;  // core clock rate
  localparam int unsigned TMR_W = 17;           // holds two bit times at 600 bps
  localparam int unsigned RATE_N = 10;          // number of offered rates
  // rate per code, code 0 is the default 115200
  localparam int unsigned RATE_BPS [0:RATE_N-1] = '{
    115200, 600, 1200, 1800, 2400, 4800, 9600, 19200, 38400, 57600
  };

  // ------------
  // line standard codes
  // ------------
  localparam logic LINE_RS485 = 1'h0;  // half duplex, default
  localparam logic LINE_RS232 = 1'h1;  // point to point (also four-wire 422)

  // ------------
  // parity codes
  // ------------
  localparam logic [2:0] PAR_NONE = 3'h0;  // default
  localparam logic [2:0] PAR_ODD = 3'h1;
  localparam logic [2:0] PAR_EVEN = 3'h2;
  localparam logic [2:0] PAR_ONE = 3'h3;
  localparam logic [2:0] PAR_ZERO = 3'h4;

  // ------------
  // data length codes
  // ------------
  localparam logic [1:0] DBITS_8 = 2'h0;  // default
  localparam logic [1:0] DBITS_5 = 2'h1;
  localparam logic [1:0] DBITS_6 = 2'h2;
  localparam logic [1:0] DBITS_7 = 2'h3;

  // ------------
  // stop length codes
  // ------------
  localparam logic [1:0] STOP_1 = 2'h0;   // default
  localparam logic [1:0] STOP_15 = 2'h1;  // five-bit characters only
  localparam logic [1:0] STOP_2 = 2'h2;   // six to eight bits only

  // ----------------------------------------------------------------
  // receive threshold codes and counts
  // ----------------------------------------------------------------
  localparam logic [1:0] THR_8 = 2'h0;  // default
  localparam logic [1:0] THR_1 = 2'h1;
  localparam logic [1:0] THR_4 = 2'h2;
  localparam logic [1:0] THR_14 = 2'h3;
  localparam logic [3:0] THR_CNT_8 = 4'h8;
  localparam logic [3:0] THR_CNT_1 = 4'h1;
  localparam logic [3:0] THR_CNT_4 = 4'h4;
  localparam logic [3:0] THR_CNT_14 = 4'he;

  // ----------------------------------------------------------------
  // receive side info field positions (extended mode)
  // ----------------------------------------------------------------
  localparam int unsigned INFO_FRAME = 0;  // stop bit sampled low
  localparam int unsigned INFO_PAR = 1;    // parity mismatch
  localparam int unsigned INFO_OVR = 2;    // bytes lost before this one
  localparam int unsigned INFO_W = 3;
  localparam int unsigned FIFO_DEPTH = 4;

  // ------------
  // state machines
  // ------------
  typedef enum logic [4:0] {
    SSP_IDLE = 5'h01,
    SSP_START = 5'h02,
    SSP_DATA = 5'h04,
    SSP_PAR = 5'h08,
    SSP_STOP = 5'h10
  } ssp_st_t;

endpackage : ssp_pkg

// [rtl/ssp_uart.sv]
// Purpose: second serial port, character framing, rates, receive queue
// Assumes: configuration ports held stable while a character is in flight
// Notes: receive queue head is registered, so rx outputs come from flops
//
// Behaviour
// - line standard selectable, RS-485 after reset
// - ten bit rates, 115200 by default
// - parity none/odd/even/one/zero, none by default
// - five to eight data bits, eight default
// - stop length 1, 1.5 or 2, one default
// - stop length legality depends on data length
// - interrupt each time threshold bytes received
// - lower threshold means earlier, more frequent interrupts
// - normal and extended mode, extended adds info
// - receive-ignore honoured only on RS-232/422 line
// - ignore option drops bytes received during transmit

// ------------------------------------------------------------------
// shift-register queue, head entry is the output flop
// ------------------------------------------------------------------
module ssp_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_ff [0:DEPTH-1];  // entry 0 is the head
  logic [DEPTH-1:0] vld_ff;              // occupancy per entry
  logic push;
  logic pop;

  if (DEPTH < 2 || WIDTH < 1) begin : g_chk
    $error("ssp_fifo: depth must be at least 2 and width at least 1");
  end

  // full only when the last slot is taken; no read-through, keeps timing flat
  assign in_ready = ~vld_ff[DEPTH-1];
  assign push = in_valid & in_ready;
  assign pop = out_ready & vld_ff[0];
  assign out_valid = vld_ff[0];
  assign out_data = mem_ff[0];

  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    logic sh_v;              // occupancy after a pop shift
    logic [WIDTH-1:0] sh_d;  // data after a pop shift
    logic below_v;           // entry below is occupied after shift
    logic nxt_v;
    logic [WIDTH-1:0] nxt_d;

    // shift down on pop, then fill the lowest free slot on push
    always_comb begin
      sh_v = vld_ff[i];
      sh_d = mem_ff[i];
      below_v = 1'b1;
      if (pop) begin
        sh_v = (i < DEPTH - 1) ? vld_ff[(i + 1) % DEPTH] : 1'b0;
        sh_d = (i < DEPTH - 1) ? mem_ff[(i + 1) % DEPTH] : mem_ff[i];
      end
      if (i > 0) begin
        below_v = pop ? vld_ff[i] : vld_ff[(i + DEPTH - 1) % DEPTH];
      end
      nxt_v = sh_v;
      nxt_d = sh_d;
      if (push && !sh_v && below_v) begin
        nxt_v = 1'b1;
        nxt_d = in_data;
      end
    end

    // register the entry
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        vld_ff[i] <= 1'b0;
        mem_ff[i] <= '0;
      end else begin
        vld_ff[i] <= nxt_v;
        mem_ff[i] <= nxt_d;
      end
    end
  end
endmodule : ssp_fifo

// ------------------------------------------------------------------
// serial port top
// ------------------------------------------------------------------
module ssp_uart (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic line_sel,         // line standard code
  input wire logic [3:0] rate_sel,   // bit rate code
  input wire logic [2:0] par_sel,    // parity code
  input wire logic [1:0] dbits_sel,  // data length code
  input wire logic [1:0] stop_sel,   // stop length code
  input wire logic [1:0] thr_sel,    // receive threshold code
  input wire logic ext_mode,         // 1 = extended mode
  input wire logic rx_ign_tx,        // drop receive while sending, RS-232/422 line only
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  output logic [ssp_pkg::INFO_W-1:0] rx_info,
  output logic rx_thr_irq,           // one-cycle pulse
  output logic rx_overrun,           // one-cycle pulse
  output logic cfg_err,              // illegal code combination
  input wire logic rxd,
  output logic txd,
  output logic drv_en                // RS-485 driver enable
);
  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  logic [ssp_pkg::TMR_W-1:0] bit_cyc;   // cycles per bit
  logic [ssp_pkg::TMR_W-1:0] stop_cyc;  // cycles of the stop interval
  logic [2:0] last_idx;                 // index of the final data bit
  logic par_en;
  logic [3:0] thr_cnt;
  logic nxt_cfg_err;
  logic cfg_err_ff;

  // every per-bit time rounds down, so rates run a hair fast at most
  function automatic logic [ssp_pkg::TMR_W-1:0] cyc_of(input logic [3:0] sel);
    int unsigned idx;
    idx = (sel < ssp_pkg::RATE_N) ? int'(sel) : 0;
    return ssp_pkg::TMR_W'(ssp_pkg::CLK_HZ / ssp_pkg::RATE_BPS[idx]);
  endfunction : cyc_of

  // decode codes; illegal stop lengths fall back to the nearest legal one
  always_comb begin
    bit_cyc = cyc_of(rate_sel);
    nxt_cfg_err = (rate_sel >= 4'(ssp_pkg::RATE_N)) || (par_sel > ssp_pkg::PAR_ZERO);
    case (dbits_sel)
      ssp_pkg::DBITS_5: last_idx = 3'h4;
      ssp_pkg::DBITS_6: last_idx = 3'h5;
      ssp_pkg::DBITS_7: last_idx = 3'h6;
      default: last_idx = 3'h7;
    endcase
    stop_cyc = bit_cyc;
    if (stop_sel == ssp_pkg::STOP_15 || stop_sel == ssp_pkg::STOP_2) begin
      // five bits take 1.5, longer characters take 2
      if (dbits_sel == ssp_pkg::DBITS_5) begin
        stop_cyc = bit_cyc + (bit_cyc >> 1);
        nxt_cfg_err = nxt_cfg_err | (stop_sel == ssp_pkg::STOP_2);
      end else begin
        stop_cyc = bit_cyc << 1;
        nxt_cfg_err = nxt_cfg_err | (stop_sel == ssp_pkg::STOP_15);
      end
    end
    nxt_cfg_err = nxt_cfg_err | (stop_sel > ssp_pkg::STOP_2);
    par_en = (par_sel != ssp_pkg::PAR_NONE) && (par_sel <= ssp_pkg::PAR_ZERO);
    case (thr_sel)
      ssp_pkg::THR_1: thr_cnt = ssp_pkg::THR_CNT_1;
      ssp_pkg::THR_4: thr_cnt = ssp_pkg::THR_CNT_4;
      ssp_pkg::THR_14: thr_cnt = ssp_pkg::THR_CNT_14;
      default: thr_cnt = ssp_pkg::THR_CNT_8;
    endcase
  end

  // parity bit for a masked character
  function automatic logic par_of(input logic [7:0] d, input logic [2:0] li,
                                  input logic [2:0] ps);
    logic [7:0] m;
    m = d & 8'((9'h002 << li) - 9'h001);
    case (ps)
      ssp_pkg::PAR_ODD: return ~(^m);
      ssp_pkg::PAR_EVEN: return ^m;
      ssp_pkg::PAR_ONE: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : par_of

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  ssp_pkg::ssp_st_t tx_st_ff, nxt_tx_st;
  logic [ssp_pkg::TMR_W-1:0] tx_tmr_ff, nxt_tx_tmr;
  logic [7:0] tx_sh_ff, nxt_tx_sh;
  logic [2:0] tx_idx_ff, nxt_tx_idx;
  logic tx_par_ff, nxt_tx_par;
  logic txd_ff, nxt_txd;
  logic tx_ready_ff, nxt_tx_ready;
  logic drv_en_ff, nxt_drv_en;

  // frame: start low, data lsb first, parity, stop high
  always_comb begin
    nxt_tx_st = tx_st_ff;
    nxt_tx_tmr = (tx_tmr_ff != '0) ? tx_tmr_ff - 1'b1 : tx_tmr_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_idx = tx_idx_ff;
    nxt_tx_par = tx_par_ff;
    nxt_txd = txd_ff;
    case (tx_st_ff)
      ssp_pkg::SSP_IDLE: begin
        nxt_txd = 1'b1;
        if (tx_valid && tx_ready_ff) begin
          nxt_tx_st = ssp_pkg::SSP_START;
          nxt_tx_sh = tx_data;
          nxt_tx_par = par_of(tx_data, last_idx, par_sel);
          nxt_tx_idx = 3'h0;
          nxt_tx_tmr = bit_cyc - 1'b1;
          nxt_txd = 1'b0;
        end
      end
      ssp_pkg::SSP_START: begin
        if (tx_tmr_ff == '0) begin
          nxt_tx_st = ssp_pkg::SSP_DATA;
          nxt_tx_tmr = bit_cyc - 1'b1;
          nxt_txd = tx_sh_ff[0];
        end
      end
      ssp_pkg::SSP_DATA: begin
        if (tx_tmr_ff == '0) begin
          nxt_tx_tmr = bit_cyc - 1'b1;
          nxt_tx_sh = tx_sh_ff >> 1;
          nxt_tx_idx = tx_idx_ff + 1'b1;
          nxt_txd = tx_sh_ff[1];
          if (tx_idx_ff == last_idx) begin
            nxt_tx_st = par_en ? ssp_pkg::SSP_PAR : ssp_pkg::SSP_STOP;
            nxt_txd = par_en ? tx_par_ff : 1'b1;
            nxt_tx_tmr = par_en ? bit_cyc - 1'b1 : stop_cyc - 1'b1;
          end
        end
      end
      ssp_pkg::SSP_PAR: begin
        if (tx_tmr_ff == '0) begin
          nxt_tx_st = ssp_pkg::SSP_STOP;
          nxt_tx_tmr = stop_cyc - 1'b1;
          nxt_txd = 1'b1;
        end
      end
      ssp_pkg::SSP_STOP: begin
        if (tx_tmr_ff == '0) begin
          nxt_tx_st = ssp_pkg::SSP_IDLE;
        end
      end
      default: begin
        nxt_tx_st = ssp_pkg::SSP_IDLE;
        nxt_txd = 1'b1;
      end
    endcase
    nxt_tx_ready = (nxt_tx_st == ssp_pkg::SSP_IDLE);
    // only the half-duplex line needs its driver turned round
    nxt_drv_en = (line_sel == ssp_pkg::LINE_RS485) && !nxt_tx_ready;
  end

  // transmitter registers, line idles high
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_st_ff <= ssp_pkg::SSP_IDLE;
      tx_tmr_ff <= '0;
      tx_sh_ff <= 8'h00;
      tx_idx_ff <= 3'h0;
      tx_par_ff <= 1'b0;
      txd_ff <= 1'b1;
      tx_ready_ff <= 1'b1;
      drv_en_ff <= 1'b0;
    end else begin
      tx_st_ff <= nxt_tx_st;
      tx_tmr_ff <= nxt_tx_tmr;
      tx_sh_ff <= nxt_tx_sh;
      tx_idx_ff <= nxt_tx_idx;
      tx_par_ff <= nxt_tx_par;
      txd_ff <= nxt_txd;
      tx_ready_ff <= nxt_tx_ready;
      drv_en_ff <= nxt_drv_en;
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  logic rxd_meta_ff, rxd_s_ff;  // two-stage synchroniser
  ssp_pkg::ssp_st_t rx_st_ff, nxt_rx_st;
  logic [ssp_pkg::TMR_W-1:0] rx_tmr_ff, nxt_rx_tmr;
  logic [7:0] rx_sh_ff, nxt_rx_sh;
  logic [2:0] rx_idx_ff, nxt_rx_idx;
  logic rx_perr_ff, nxt_rx_perr;
  logic rx_drop_ff, nxt_rx_drop;
  logic push_ff, nxt_push;
  logic [7:0] push_d_ff, nxt_push_d;
  logic [ssp_pkg::INFO_W-1:0] push_i_ff, nxt_push_i;
  logic ovr_seen_ff, nxt_ovr_seen;
  logic ovr_ff, nxt_ovr;
  logic [3:0] thr_ff, nxt_thr;
  logic irq_ff, nxt_irq;
  logic q_ready;
  logic q_take;

  assign q_take = push_ff & q_ready;

  // receive framing, sampled at mid-bit; then queue bookkeeping
  always_comb begin
    nxt_rx_st = rx_st_ff;
    nxt_rx_tmr = (rx_tmr_ff != '0) ? rx_tmr_ff - 1'b1 : rx_tmr_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_idx = rx_idx_ff;
    nxt_rx_perr = rx_perr_ff;
    // a byte overlapping any transmit time is dropped on a full-duplex line when rx_ign_tx is set
    nxt_rx_drop = rx_drop_ff | (tx_st_ff != ssp_pkg::SSP_IDLE);
    nxt_push = 1'b0;
    nxt_push_d = push_d_ff;
    nxt_push_i = push_i_ff;
    case (rx_st_ff)
      ssp_pkg::SSP_IDLE: begin
        nxt_rx_drop = (tx_st_ff != ssp_pkg::SSP_IDLE);
        if (!rxd_s_ff) begin
          nxt_rx_st = ssp_pkg::SSP_START;
          nxt_rx_tmr = (bit_cyc >> 1) - 1'b1;
        end
      end
      ssp_pkg::SSP_START: begin
        if (rx_tmr_ff == '0) begin
          // a glitch shorter than half a bit is not a start
          nxt_rx_st = rxd_s_ff ? ssp_pkg::SSP_IDLE : ssp_pkg::SSP_DATA;
          nxt_rx_tmr = bit_cyc - 1'b1;
          nxt_rx_sh = 8'h00;
          nxt_rx_idx = 3'h0;
          nxt_rx_perr = 1'b0;
        end
      end
      ssp_pkg::SSP_DATA: begin
        if (rx_tmr_ff == '0) begin
          nxt_rx_sh[rx_idx_ff] = rxd_s_ff;
          nxt_rx_idx = rx_idx_ff + 1'b1;
          nxt_rx_tmr = bit_cyc - 1'b1;
          if (rx_idx_ff == last_idx) begin
            nxt_rx_st = par_en ? ssp_pkg::SSP_PAR : ssp_pkg::SSP_STOP;
          end
        end
      end
      ssp_pkg::SSP_PAR: begin
        if (rx_tmr_ff == '0) begin
          nxt_rx_perr = rxd_s_ff != par_of(rx_sh_ff, last_idx, par_sel);
          nxt_rx_st = ssp_pkg::SSP_STOP;
          nxt_rx_tmr = bit_cyc - 1'b1;
        end
      end
      ssp_pkg::SSP_STOP: begin
        if (rx_tmr_ff == '0) begin
          nxt_rx_st = ssp_pkg::SSP_IDLE;
          nxt_push = !(rx_drop_ff && rx_ign_tx && line_sel == ssp_pkg::LINE_RS232);
          nxt_push_d = rx_sh_ff;
          nxt_push_i = '0;
          if (ext_mode) begin
            nxt_push_i[ssp_pkg::INFO_FRAME] = !rxd_s_ff;
            nxt_push_i[ssp_pkg::INFO_PAR] = rx_perr_ff;
            nxt_push_i[ssp_pkg::INFO_OVR] = ovr_seen_ff;
          end
        end
      end
      default: nxt_rx_st = ssp_pkg::SSP_IDLE;
    endcase
    // a full queue loses the byte; the loss is flagged on the next one
    nxt_ovr = push_ff & ~q_ready;
    nxt_ovr_seen = nxt_ovr | (ovr_seen_ff & ~q_take);
    // threshold counter restarts after each interrupt
    nxt_thr = thr_ff;
    nxt_irq = 1'b0;
    if (q_take) begin
      nxt_thr = thr_ff + 1'b1;
      if (thr_ff + 1'b1 >= thr_cnt) begin
        nxt_thr = 4'h0;
        nxt_irq = 1'b1;
      end
    end
  end

  // receiver registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rxd_meta_ff <= 1'b1;
      rxd_s_ff <= 1'b1;
      rx_st_ff <= ssp_pkg::SSP_IDLE;
      rx_tmr_ff <= '0;
      rx_sh_ff <= 8'h00;
      rx_idx_ff <= 3'h0;
      rx_perr_ff <= 1'b0;
      rx_drop_ff <= 1'b0;
      push_ff <= 1'b0;
      push_d_ff <= 8'h00;
      push_i_ff <= '0;
      ovr_seen_ff <= 1'b0;
      ovr_ff <= 1'b0;
      thr_ff <= 4'h0;
      irq_ff <= 1'b0;
      cfg_err_ff <= 1'b0;
    end else begin
      rxd_meta_ff <= rxd;
      rxd_s_ff <= rxd_meta_ff;
      rx_st_ff <= nxt_rx_st;
      rx_tmr_ff <= nxt_rx_tmr;
      rx_sh_ff <= nxt_rx_sh;
      rx_idx_ff <= nxt_rx_idx;
      rx_perr_ff <= nxt_rx_perr;
      rx_drop_ff <= nxt_rx_drop;
      push_ff <= nxt_push;
      push_d_ff <= nxt_push_d;
      push_i_ff <= nxt_push_i;
      ovr_seen_ff <= nxt_ovr_seen;
      ovr_ff <= nxt_ovr;
      thr_ff <= nxt_thr;
      irq_ff <= nxt_irq;
      cfg_err_ff <= nxt_cfg_err;
    end
  end

  // ----------------------------------------------------------------
  // receive queue and outputs
  // ----------------------------------------------------------------
  ssp_fifo #(
    .WIDTH(8 + ssp_pkg::INFO_W),
    .DEPTH(ssp_pkg::FIFO_DEPTH)
  ) u_rxq (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .in_valid(push_ff),
    .in_ready(q_ready),
    .in_data({push_i_ff, push_d_ff}),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data({rx_info, rx_data})
  );

  assign tx_ready = tx_ready_ff;
  assign txd = txd_ff;
  assign drv_en = drv_en_ff;
  assign rx_thr_irq = irq_ff;
  assign rx_overrun = ovr_ff;
  assign cfg_err = cfg_err_ff;
endmodule : ssp_uart

// [bench/ssp_station.sv]
// Purpose: remote serial station facing the port's rxd and txd pins
// Assumes: bit length in core_clk cycles is given per call
// Notes: line idles high between frames, like a pulled-up receiver input

module ssp_station (
  input wire logic core_clk,
  output logic rxd,
  input wire logic txd
);
  timeunit 1ns;
  timeprecision 1ns;

  initial rxd = 1'h1;  // idle level

  // ------------
  // send one character, pb < 0 means no parity bit
  // ------------
  task automatic send(input logic [7:0] d, input int n, input int b, input int pb);
    @(negedge core_clk);
    rxd = 1'h0;
    repeat (b) @(negedge core_clk);
    for (int i = 0; i < n; i++) begin
      rxd = d[i];
      repeat (b) @(negedge core_clk);
    end
    if (pb >= 0) begin
      rxd = pb[0];
      repeat (b) @(negedge core_clk);
    end
    rxd = 1'h1;
    repeat (b) @(negedge core_clk);
  endtask : send

  // ------------
  // catch one character, sampled mid-bit; stop checked by frame length
  // ------------
  task automatic catch(input int n, input int b, input bit hp, output logic [7:0] d,
                       output logic p);
    d = 8'h00;
    p = 1'h0;
    wait (txd === 1'h0);
    repeat (b / 2) @(posedge core_clk);
    for (int i = 0; i < n; i++) begin
      repeat (b) @(posedge core_clk);
      d[i] = txd;
    end
    if (hp) begin
      repeat (b) @(posedge core_clk);
      p = txd;
    end
  endtask : catch
endmodule : ssp_station

// [bench/ssp_uart_asserts.sv]
// Purpose: port-level checks of the serial port
// Assumes: configuration only changes while the transmitter is idle
// Notes: bound to every ssp_uart instance

module ssp_uart_asserts (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic line_sel,
  input wire logic [3:0] rate_sel,
  input wire logic [2:0] par_sel,
  input wire logic [1:0] stop_sel,
  input wire logic ext_mode,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic txd,
  input wire logic drv_en,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] rx_data,
  input wire logic [ssp_pkg::INFO_W-1:0] rx_info,
  input wire logic rx_thr_irq,
  input wire logic cfg_err
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // ------------
  // transmit steps
  // ------------
  sequence s_take;
    tx_valid && tx_ready;
  endsequence
  sequence s_start;
    (!txd && !tx_ready)[*8];
  endsequence

  a_start_low: assert property (s_take |=> s_start)
    else $error("start bit not driven low");
  a_idle_high: assert property (tx_ready |-> txd && !drv_en)
    else $error("idle line not high");
  a_drv_485: assert property (s_take ##0 (line_sel == ssp_pkg::LINE_RS485) |=> drv_en[*8])
    else $error("driver not enabled in frame");
  a_drv_232: assert property (line_sel == ssp_pkg::LINE_RS232 |-> !drv_en)
    else $error("driver enabled on point line");

  // ------------
  // receive side
  // ------------
  a_info_norm: assert property (rx_valid && !ext_mode |-> rx_info == '0)
    else $error("info set in normal mode");
  a_head_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("queue head changed unpopped");
  a_irq_pulse: assert property ($rose(rx_thr_irq) |=> !rx_thr_irq)
    else $error("threshold pulse too long");

  // ------------
  // illegal codes
  // ------------
  a_cfg_rate: assert property (rate_sel > 4'h9 |=> cfg_err)
    else $error("bad rate code not flagged");
  a_cfg_par: assert property (par_sel > ssp_pkg::PAR_ZERO |=> cfg_err)
    else $error("bad parity code not flagged");
  a_cfg_stop: assert property (stop_sel == 2'h3 |=> cfg_err)
    else $error("bad stop code not flagged");
endmodule : ssp_uart_asserts

bind ssp_uart ssp_uart_asserts u_ssp_uart_asserts (.core_clk, .reset_n, .line_sel, .rate_sel,
  .par_sel, .stop_sel, .ext_mode, .tx_valid, .tx_ready, .txd, .drv_en, .rx_valid, .rx_ready,
  .rx_data, .rx_info, .rx_thr_irq, .cfg_err);

// [bench/test_ssp_uart.sv]
// Purpose: self-checking bench of the serial port against a queue model
// Assumes: 20 MHz clock, most traffic at the default rate to keep runs short
// Notes: inputs change on the falling edge only

module test_ssp_uart;
  timeunit 1ns;
  timeprecision 1ns;

  logic core_clk, reset_n, line_sel, ext_mode, rx_ign_tx, tx_valid, rx_ready, rxd;
  logic tx_ready, rx_valid, rx_thr_irq, rx_overrun, cfg_err, txd, drv_en;
  logic [3:0] rate_sel;
  logic [2:0] par_sel;
  logic [1:0] dbits_sel, stop_sel, thr_sel;
  logic [7:0] tx_data, rx_data;
  logic [ssp_pkg::INFO_W-1:0] rx_info;
  int error_cnt = 0, total_checks = 0, irq_n = 0, ovr_n = 0;
  logic [7:0] exp_q[$];  // bytes the model expects in the queue

  ssp_uart u_ssp_uart (.core_clk, .reset_n, .line_sel, .rate_sel, .par_sel, .dbits_sel,
    .stop_sel, .thr_sel, .ext_mode, .rx_ign_tx, .tx_valid, .tx_data, .tx_ready, .rx_valid,
    .rx_ready, .rx_data, .rx_info, .rx_thr_irq, .rx_overrun, .cfg_err, .rxd, .txd, .drv_en);
  ssp_station u_ssp_station (.core_clk, .rxd, .txd);

  initial begin
    core_clk = 1'h0;
    forever #25 core_clk = ~core_clk;
  end

  // pulse counters, one count per high cycle
  always @(posedge core_clk) begin
    if (rx_thr_irq === 1'h1) irq_n++;
    if (rx_overrun === 1'h1) ovr_n++;
  end

  // ------------
  // helpers
  // ------------
  task automatic chk(input bit c, input string m);
    total_checks++;
    if (!c) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  function automatic int nb(input logic [1:0] c);
    return (c == ssp_pkg::DBITS_8) ? 8 : int'(c) + 4;
  endfunction : nb

  function automatic int bl(input logic [3:0] c);
    return int'(ssp_pkg::CLK_HZ / ssp_pkg::RATE_BPS[c]);
  endfunction : bl

  // parity bit for the current code, -1 when none
  function automatic int pv(input logic [7:0] d);
    case (par_sel)
      ssp_pkg::PAR_ODD: return int'(~^d);
      ssp_pkg::PAR_EVEN: return int'(^d);
      ssp_pkg::PAR_ONE: return 1;
      ssp_pkg::PAR_ZERO: return 0;
      default: return -1;
    endcase
  endfunction : pv

  task automatic tx_one(input logic [7:0] d);
    int n, b, p, s, k;
    logic [7:0] m, got;
    logic gp;
    n = nb(dbits_sel);
    b = bl(rate_sel);
    m = d & (8'hff >> (8 - n));
    p = pv(m);
    s = (stop_sel == ssp_pkg::STOP_1) ? b : ((n == 5) ? b + b / 2 : 2 * b);
    tx_data = d;
    tx_valid = 1'h1;
    fork
      u_ssp_station.catch(n, b, p >= 0, got, gp);
      begin
        @(negedge core_clk);
        tx_valid = 1'h0;
        for (k = 0; tx_ready !== 1'h1 && k < 40000; k++)
          @(negedge core_clk);
      end
    join
    chk(got === m, "tx data bits");
    chk(p < 0 || gp === p[0], "tx parity bit");
    chk(k == b * (1 + n + (p >= 0)) + s, "tx frame length");
  endtask : tx_one

  task automatic rx_one(input logic [7:0] d, input bit bad);
    int n, p;
    logic [7:0] m;
    n = nb(dbits_sel);
    m = d & (8'hff >> (8 - n));
    p = pv(m);
    if (bad) p = 1 - p;  // corrupt the parity bit
    exp_q.push_back(m);
    u_ssp_station.send(d, n, bl(rate_sel), p);
  endtask : rx_one

  task automatic pop_chk(input logic [ssp_pkg::INFO_W-1:0] inf);
    for (int t = 0; rx_valid !== 1'h1 && t < 4000; t++)
      @(negedge core_clk);
    chk(rx_data === exp_q.pop_front(), "rx data");
    chk(rx_info === inf, "rx info");
    rx_ready = 1'h1;
    @(negedge core_clk);
    rx_ready = 1'h0;
    @(negedge core_clk);  // strobe low a full cycle
  endtask : pop_chk

  // hang guard, a fifth over the expected run of about 4 ms
  initial begin
    #4_750_000;
    error_cnt++;
    finish_test();
  end

  // ------------
  // main sequence
  // ------------
  initial begin
    int tc[4];
    int base, ob;
    tc = '{8, 1, 4, 14};  // threshold counts per code
    {reset_n, line_sel, ext_mode, rx_ign_tx, tx_valid, rx_ready} = 6'h00;
    {rate_sel, par_sel, dbits_sel, stop_sel, thr_sel, tx_data} = 21'h0;
    repeat (10) @(negedge core_clk);
    chk({txd, tx_ready, drv_en, rx_valid} === 4'hc, "reset values");
    reset_n = 1'h1;
    void'($urandom(36460));
    // every threshold code, counter starts from zero after reset
    for (int j = 0; j < 4; j++) begin
      thr_sel = 2'(j);
      ext_mode = j[0];
      for (int k = 0; k < tc[j]; k++) begin
        base = irq_n;
        rx_one(8'($urandom), 1'b0);
        pop_chk('0);
        chk(irq_n == base + (k == tc[j] - 1), "threshold pulse");
      end
    end
    // parity error flagged only in extended mode
    thr_sel = ssp_pkg::THR_1;
    par_sel = ssp_pkg::PAR_EVEN;
    for (int e = 0; e < 2; e++) begin
      ext_mode = e[0];
      rx_one(8'($urandom), 1'b1);
      pop_chk(e ? 3'h2 : 3'h0);
    end
    // queue full: fifth byte lost, next byte carries the lost flag
    par_sel = ssp_pkg::PAR_NONE;
    thr_sel = ssp_pkg::THR_4;
    base = irq_n;
    ob = ovr_n;
    repeat (5) rx_one(8'($urandom), 1'b0);
    repeat (4) @(negedge core_clk);
    void'(exp_q.pop_back());
    chk(ovr_n == ob + 1, "overrun pulse");
    chk(irq_n == base + 1, "threshold with full queue");
    repeat (4) pop_chk('0);
    rx_one(8'($urandom), 1'b0);
    pop_chk(3'h4);
    // transmit sweep over parity codes, data lengths, stops and lines
    ext_mode = 1'h0;
    for (int i = 0; i < 8; i++) begin
      par_sel = 3'(i % 5);
      dbits_sel = 2'(i);
      stop_sel = ($urandom % 2) ? ((i % 4 == 1) ? ssp_pkg::STOP_15 : ssp_pkg::STOP_2) : 2'h0;
      line_sel = 1'(i);
      rate_sel = (i == 7) ? 4'h9 : 4'h0;
      tx_one(8'($urandom));
    end
    // illegal codes, one at a time
    for (int i = 0; i < 12; i++) begin
      rate_sel = (i < 6) ? 4'(10 + i) : 4'h0;
      par_sel = (i >= 6 && i < 9) ? 3'(i - 1) : 3'h0;
      {dbits_sel, stop_sel} = (i == 9) ? 4'h3 : (i == 10) ? 4'h6 : (i == 11) ? 4'h1 : 4'h0;
      repeat (2) @(negedge core_clk);
      chk(cfg_err === 1'h1, "illegal code accepted");
    end
    {rate_sel, par_sel, dbits_sel, stop_sel} = 11'h0;
    repeat (2) @(negedge core_clk);
    chk(cfg_err === 1'h0, "legal codes flagged");
    // receive during transmit: dropped on point line only
    rx_ign_tx = 1'h1;
    for (int li = 0; li < 2; li++) begin
      line_sel = li[0];
      fork
        tx_one(8'($urandom));
        begin
          repeat (20) @(negedge core_clk);
          rx_one(8'($urandom), 1'b0);
        end
      join
      if (li == 1) begin
        repeat (4) @(negedge core_clk);
        chk(rx_valid === 1'h0, "byte kept while sending");
        void'(exp_q.pop_back());
      end
      else pop_chk('0);
    end
    finish_test();
  end
endmodule : test_ssp_uart
